// ---- hw/srss_pkg.sv ----
// Purpose: Shared constants and types for the status reporting and setup store block
// Assumes: Commands arrive already parsed, one per cycle, from a message front end
// Notes:   Slot parameters are signed fixed point with SRSS_FRAC_BITS fraction bits
package srss_pkg;

  // Status byte field positions
  localparam int unsigned SRSS_BIT_MAV = 4;
  localparam int unsigned SRSS_BIT_ESB = 5;
  localparam int unsigned SRSS_BIT_RQS = 6;

  // Mask of the bits that read back from the enable mask
  localparam logic [7:0] SRSS_MASK_READ  = 8'h30;
  // Bit that is always enabled in operation
  localparam logic [7:0] SRSS_MASK_FORCE = 8'h40;
  // Bits that take part in the summary
  localparam logic [7:0] SRSS_SUM_BITS   = 8'h30;
  localparam logic [7:0] SRSS_MASK_RESET = 8'h00;
  localparam logic [7:0] SRSS_BYTE_ZERO  = 8'h00;

  // Parameter format and ranges
  localparam int unsigned SRSS_PARAM_W   = 16;
  localparam int unsigned SRSS_FRAC_BITS = 4;
  localparam int unsigned SRSS_ROUND_W   = SRSS_PARAM_W + 1 - SRSS_FRAC_BITS;
  localparam logic signed [SRSS_PARAM_W:0]   SRSS_HALF     = 17'sh00008;
  localparam logic signed [SRSS_ROUND_W-1:0] SRSS_MASK_MIN = 13'sh0000;
  localparam logic signed [SRSS_ROUND_W-1:0] SRSS_MASK_MAX = 13'sh00ff;
  localparam logic signed [SRSS_ROUND_W-1:0] SRSS_SLOT_MIN = 13'sh0001;
  localparam logic signed [SRSS_ROUND_W-1:0] SRSS_SLOT_LIM = 13'sh000a;

  // Setup store geometry
  localparam int unsigned SRSS_SLOTS    = 9;
  localparam int unsigned SRSS_SLOT_W   = 4;
  localparam int unsigned SRSS_SETUP_W  = 32;
  localparam logic [SRSS_SLOT_W-1:0]  SRSS_SLOT_ONE  = 4'h1;
  localparam logic [SRSS_SETUP_W-1:0] SRSS_SETUP_RST = 32'h00000000;

  typedef enum logic [2:0] {
    SRSS_OP_NONE      = 3'b000,
    SRSS_OP_SRE_SET   = 3'b001,
    SRSS_OP_SRE_QUERY = 3'b010,
    SRSS_OP_STB_QUERY = 3'b011,
    SRSS_OP_TRIGGER   = 3'b100,
    SRSS_OP_RECALL    = 3'b101,
    SRSS_OP_SAVE      = 3'b110
  } srss_op_t;

  typedef enum logic [1:0] {
    SRSS_MODE_CONTINUOUS_OSCILLATION = 2'b00,
    SRSS_MODE_GATE                   = 2'b01,
    SRSS_MODE_TRIGGERED              = 2'b10
  } srss_mode_t;

  typedef struct packed {
    logic                           valid;
    srss_op_t                       op;
    logic                           has_param;
    logic signed [SRSS_PARAM_W-1:0] param;
  } srss_cmd_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } srss_reply_t;

endpackage

// ---- hw/srss_setup_store.sv ----
// Purpose: Nine slot store of instrument setups for save and recall
// Assumes: Slot number already checked to lie in 1..9
// Notes:   Read data appears one cycle after the read strobe
`timescale 1ns/1ns
`default_nettype none
module srss_setup_store (
  // Clock and reset
  input  wire logic                              i_clock,
  input  wire logic                              i_rst,
  // Access
  input  wire logic                              i_wr,
  input  wire logic                              i_rd,
  input  wire logic [srss_pkg::SRSS_SLOT_W-1:0]  i_slot,
  input  wire logic [srss_pkg::SRSS_SETUP_W-1:0] i_wdata,
  // Read result
  output logic      [srss_pkg::SRSS_SETUP_W-1:0] o_rdata,
  output logic                                   o_rvalid
);

  logic [srss_pkg::SRSS_SETUP_W-1:0] slot_mem [srss_pkg::SRSS_SLOTS];
  logic [srss_pkg::SRSS_SLOT_W-1:0]  index;

  assign index = i_slot - srss_pkg::SRSS_SLOT_ONE;

  // No reset on the array, so it maps onto plain storage
  always_ff @(posedge i_clock) begin
    if (i_wr) begin
      slot_mem[index] <= i_wdata;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_rdata  <= srss_pkg::SRSS_SETUP_RST;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= i_rd;
      if (i_rd) begin
        o_rdata <= slot_mem[index];
      end
    end
  end

endmodule // srss_setup_store
`default_nettype wire

// ---- hw/srss_top.sv ----
// Purpose: Status byte, service request enable mask, trigger and setup save/recall handling
// Assumes: Commands, poll and group trigger strobes come from logic on i_clock
// Notes:   i_rst stands for power-on; kept mask is reloaded after it unless clearing is asked
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Mask set command loads the enable mask from a 0..255 parameter.
// - Mask bit 1 lets its status bit raise a request; 0 blocks it.
// - Mask query returns only bits 5 and 4; bit 6 reads zero, max 48.
// - Mask bit 6 always counts as enabled in operation.
// - Status byte: request bit 6, event summary bit 5, message available bit 4.
// - Status query returns master summary in bit 6, others as poll; max 112.
// - Master summary is OR of masked status bits excluding bit 6.
// - Request bit latches until serial poll; master summary follows status live.
// - Trigger command starts a manual trigger.
// - Trigger command and group trigger ignored in continuous and gate modes.
// - Recall restores the setup from slot 1..9 shared with front panel.
// - Recall without a slot number flags a command error.
// - Recall slot rounded; below 1 or 10 and up flags execution error.
// - Save stores the current setup into slot 1..9.
// - Save slot rounded; below 1 or 10 and up flags error, nothing stored.
// - Power-on clear flag chooses cleared or kept enable mask at power-up.
module srss_top (
  // Clock and reset
  input  wire logic                              i_clock,
  input  wire logic                              i_rst,
  // Parsed commands
  input  wire srss_pkg::srss_cmd_t               i_cmd,
  input  wire logic                              i_group_trigger,
  input  wire logic                              i_serial_poll,
  // Status sources
  input  wire logic [7:0]                        i_event_status,
  input  wire logic [7:0]                        i_event_enable,
  input  wire logic                              i_queue_has_data,
  input  wire srss_pkg::srss_mode_t              i_osc_mode,
  // Power-on handling
  input  wire logic                              i_psc_flag,
  input  wire logic [7:0]                        i_kept_mask,
  // Current setup
  input  wire logic [srss_pkg::SRSS_SETUP_W-1:0] i_setup,
  // Query replies and poll
  output srss_pkg::srss_reply_t                  o_reply,
  output logic [7:0]                             o_poll_byte,
  output logic                                   o_poll_valid,
  output logic                                   o_srq,
  output logic                                   o_mss,
  output logic [7:0]                             o_mask_keep,
  // Actions
  output logic                                   o_trigger,
  output logic [srss_pkg::SRSS_SETUP_W-1:0]      o_setup,
  output logic                                   o_setup_load,
  // Errors
  output logic                                   o_cmd_error,
  output logic                                   o_exe_error
);

  // Rounds a fixed point parameter half up to an integer
  function automatic logic signed [srss_pkg::SRSS_ROUND_W-1:0] round_param(
    input logic signed [srss_pkg::SRSS_PARAM_W-1:0] p
  );
    logic signed [srss_pkg::SRSS_PARAM_W:0] s;
    s = {p[srss_pkg::SRSS_PARAM_W-1], p} + srss_pkg::SRSS_HALF;
    return s[srss_pkg::SRSS_PARAM_W:srss_pkg::SRSS_FRAC_BITS];
  endfunction

  logic                                      init_done_q;
  logic [7:0]                                mask_q;
  logic                                      rqs_q;
  logic                                      mss_prev_q;
  logic                                      store_wr_q;
  logic                                      store_rd_q;
  logic [srss_pkg::SRSS_SLOT_W-1:0]          slot_q;
  logic [srss_pkg::SRSS_SETUP_W-1:0]         save_data_q;
  logic [srss_pkg::SRSS_SETUP_W-1:0]         store_rdata;
  logic                                      store_rvalid;
  logic                                      esb;
  logic                                      mav;
  logic [7:0]                                mask_eff;
  logic [7:0]                                stb_base;
  logic                                      mss_now;
  logic                                      rqs_set;
  logic signed [srss_pkg::SRSS_ROUND_W-1:0]  rounded;
  logic                                      slot_ok;
  logic                                      mask_ok;
  logic                                      trig_allowed;
  logic                                      is_sre_set;
  logic                                      is_recall;
  logic                                      is_save;
  logic                                      is_trigger;
  logic                                      trig_req;
  logic [7:0]                                poll_byte_d;
  logic [7:0]                                stb_reply_d;

  assign esb = |(i_event_status & i_event_enable);
  assign mav = i_queue_has_data;

  // status byte layout, unused bits zero
  always_comb begin
    stb_base = srss_pkg::SRSS_BYTE_ZERO;
    stb_base[srss_pkg::SRSS_BIT_ESB] = esb;
    stb_base[srss_pkg::SRSS_BIT_MAV] = mav;
  end

  assign mask_eff = mask_q | srss_pkg::SRSS_MASK_FORCE;

  assign mss_now = |(stb_base & mask_eff & srss_pkg::SRSS_SUM_BITS);

  // set on rising summary when clear
  // A summary held high asks only once; after the poll it stays quiet
  assign rqs_set = mss_now & ~mss_prev_q & ~rqs_q;

  // query and poll bytes differ only in bit 6
  always_comb begin
    poll_byte_d                         = stb_base;
    poll_byte_d[srss_pkg::SRSS_BIT_RQS] = rqs_q;
    stb_reply_d                         = stb_base;
    stb_reply_d[srss_pkg::SRSS_BIT_RQS] = mss_now;
  end

  assign rounded    = round_param(i_cmd.param);
  assign slot_ok    = (rounded >= srss_pkg::SRSS_SLOT_MIN) && (rounded < srss_pkg::SRSS_SLOT_LIM);
  assign mask_ok    = (rounded >= srss_pkg::SRSS_MASK_MIN) && (rounded <= srss_pkg::SRSS_MASK_MAX);
  assign is_sre_set = i_cmd.valid && (i_cmd.op == srss_pkg::SRSS_OP_SRE_SET);
  assign is_recall  = i_cmd.valid && (i_cmd.op == srss_pkg::SRSS_OP_RECALL);
  assign is_save    = i_cmd.valid && (i_cmd.op == srss_pkg::SRSS_OP_SAVE);
  assign is_trigger = i_cmd.valid && (i_cmd.op == srss_pkg::SRSS_OP_TRIGGER);
  // group trigger passes the same mode gate
  assign trig_req   = is_trigger || i_group_trigger;

  always_comb begin
    case (i_osc_mode)
      srss_pkg::SRSS_MODE_CONTINUOUS_OSCILLATION: trig_allowed = 1'b0;
      srss_pkg::SRSS_MODE_GATE:                   trig_allowed = 1'b0;
      srss_pkg::SRSS_MODE_TRIGGERED:              trig_allowed = 1'b1;
      default:                                    trig_allowed = 1'b0;
    endcase
  end

  // Power-up load is one cycle after release so no port value enters the reset branch
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      init_done_q <= 1'b0;
    end else begin
      init_done_q <= 1'b1;
    end
  end

  // Enable mask register
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      mask_q <= srss_pkg::SRSS_MASK_RESET;
    end else if (!init_done_q) begin
      if (i_psc_flag) begin
        mask_q <= srss_pkg::SRSS_MASK_RESET;
      end else begin
        mask_q <= i_kept_mask;
      end
    end else if (is_sre_set && i_cmd.has_param && mask_ok) begin
      mask_q <= rounded[7:0];
    end
  end

  // Copy for non-volatile keeping by the surrounding system
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_mask_keep <= srss_pkg::SRSS_MASK_RESET;
    end else begin
      o_mask_keep <= mask_q;
    end
  end

  // Request service latch
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rqs_q      <= 1'b0;
      mss_prev_q <= 1'b0;
    end else begin
      mss_prev_q <= mss_now;
      // a new request beats a poll clear in the same cycle
      if (rqs_set) begin
        rqs_q <= 1'b1;
      end else if (i_serial_poll) begin
        rqs_q <= 1'b0;
      end
    end
  end

  // Service request line and live summary
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_srq <= 1'b0;
      o_mss <= 1'b0;
    end else begin
      o_srq <= rqs_q | rqs_set;
      o_mss <= mss_now;
    end
  end

  // Serial poll answer carries the latched request bit
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_poll_byte  <= srss_pkg::SRSS_BYTE_ZERO;
      o_poll_valid <= 1'b0;
    end else begin
      o_poll_valid <= i_serial_poll;
      if (i_serial_poll) begin
        o_poll_byte <= poll_byte_d;
      end
    end
  end

  // Query replies
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_reply <= '0;
    end else begin
      o_reply.valid <= 1'b0;
      if (i_cmd.valid && init_done_q) begin
        case (i_cmd.op)
          srss_pkg::SRSS_OP_SRE_QUERY: begin
            // only bits 5 and 4 read back
            o_reply.valid <= 1'b1;
            o_reply.data  <= mask_q & srss_pkg::SRSS_MASK_READ;
          end
          srss_pkg::SRSS_OP_STB_QUERY: begin
            o_reply.valid <= 1'b1;
            o_reply.data  <= stb_reply_d;
          end
          default: begin
            o_reply.valid <= 1'b0;
          end
        endcase
      end
    end
  end

  // Manual trigger
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_trigger <= 1'b0;
    end else begin
      o_trigger <= init_done_q && trig_req && trig_allowed;
    end
  end

  // Save and recall requests to the slot store
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      store_wr_q  <= 1'b0;
      store_rd_q  <= 1'b0;
      slot_q      <= srss_pkg::SRSS_SLOT_ONE;
      save_data_q <= srss_pkg::SRSS_SETUP_RST;
    end else begin
      store_wr_q <= 1'b0;
      store_rd_q <= 1'b0;
      // a bad slot never reaches the store
      if (init_done_q && i_cmd.has_param && slot_ok) begin
        if (is_save) begin
          store_wr_q  <= 1'b1;
          slot_q      <= rounded[srss_pkg::SRSS_SLOT_W-1:0];
          save_data_q <= i_setup;
        end
        if (is_recall) begin
          store_rd_q <= 1'b1;
          slot_q     <= rounded[srss_pkg::SRSS_SLOT_W-1:0];
        end
      end
    end
  end

  srss_setup_store u_store (
    .i_clock  (i_clock),
    .i_rst    (i_rst),
    .i_wr     (store_wr_q),
    .i_rd     (store_rd_q),
    .i_slot   (slot_q),
    .i_wdata  (save_data_q),
    .o_rdata  (store_rdata),
    .o_rvalid (store_rvalid)
  );

  // Recalled setup handed to the instrument
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_setup      <= srss_pkg::SRSS_SETUP_RST;
      o_setup_load <= 1'b0;
    end else begin
      o_setup_load <= store_rvalid;
      if (store_rvalid) begin
        o_setup <= store_rdata;
      end
    end
  end

  // Error reporting, one-cycle pulses
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_cmd_error <= 1'b0;
      o_exe_error <= 1'b0;
    end else begin
      o_cmd_error <= 1'b0;
      o_exe_error <= 1'b0;
      if (init_done_q) begin
        // missing slot number
        // Missing parameters on save and mask set treated the same way
        if ((is_recall || is_save || is_sre_set) && !i_cmd.has_param) begin
          o_cmd_error <= 1'b1;
        end
        if (is_recall && i_cmd.has_param && !slot_ok) begin
          o_exe_error <= 1'b1;
        end
        if (is_save && i_cmd.has_param && !slot_ok) begin
          o_exe_error <= 1'b1;
        end
        // mask value outside 0..255, mask left as it was
        if (is_sre_set && i_cmd.has_param && !mask_ok) begin
          o_exe_error <= 1'b1;
        end
      end
    end
  end

endmodule // srss_top
`default_nettype wire

// ---- verification/srss_host.sv ----
// Purpose: Remote controller model issuing parsed commands, triggers and polls
// Assumes: Driven between clock edges, one-cycle strobes
// Notes:   Idle parameter lines toggle so stale values never look valid
`timescale 1ns/1ns
`default_nettype none
module srss_host (
  // Clock
  input  wire logic          i_clock,
  // Requests to the device
  output srss_pkg::srss_cmd_t o_cmd,
  output logic               o_group_trigger,
  output logic               o_serial_poll
);
  initial begin
    o_cmd = '0;
    o_group_trigger = 1'b0;
    o_serial_poll = 1'b0;
  end
  task automatic send(input srss_pkg::srss_op_t op, input logic hp, input int p);
    @(negedge i_clock);
    o_cmd = {1'b1, op, hp, p[15:0]};
    @(negedge i_clock);
    o_cmd.valid = 1'b0;
    o_cmd.param = ~o_cmd.param;
  endtask
  task automatic pulse(input logic poll);
    @(negedge i_clock);
    if (poll) o_serial_poll = 1'b1;
    else o_group_trigger = 1'b1;
    @(negedge i_clock);
    o_serial_poll = 1'b0;
    o_group_trigger = 1'b0;
  endtask
endmodule // srss_host
`default_nettype wire

// ---- verification/srss_top_properties.sv ----
// Purpose: Port-level checker for the status reporting and setup store
// Assumes: One clock domain, asynchronous active-high reset
// Notes:   Commands at the first edge after reset are ignored, hence live_q
`timescale 1ns/1ns
`default_nettype none
module srss_top_properties (
  // Clock and reset
  input  wire logic                  i_clock,
  input  wire logic                  i_rst,
  // Requests and status sources
  input  wire srss_pkg::srss_cmd_t   i_cmd,
  input  wire logic                  i_group_trigger,
  input  wire logic                  i_serial_poll,
  input  wire logic [7:0]            i_event_status,
  input  wire logic [7:0]            i_event_enable,
  input  wire logic                  i_queue_has_data,
  input  wire srss_pkg::srss_mode_t  i_osc_mode,
  // Design outputs
  input  wire srss_pkg::srss_reply_t o_reply,
  input  wire logic [7:0]            o_poll_byte,
  input  wire logic                  o_poll_valid,
  input  wire logic                  o_srq,
  input  wire logic                  o_mss,
  input  wire logic                  o_trigger,
  input  wire logic                  o_setup_load,
  input  wire logic                  o_cmd_error,
  input  wire logic                  o_exe_error
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  logic               live_q;
  logic signed [16:0] rnd_w;
  logic               esb_w;
  logic               go_w;
  logic               slot_w;
  assign rnd_w  = ($signed({i_cmd.param[15], i_cmd.param}) + srss_pkg::SRSS_HALF) >>> 4;
  assign esb_w  = |(i_event_status & i_event_enable);
  assign go_w   = live_q && ((i_cmd.valid && i_cmd.op == srss_pkg::SRSS_OP_TRIGGER) || i_group_trigger);
  assign slot_w = live_q && i_cmd.valid && i_cmd.has_param;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) live_q <= 1'b0;
    else live_q <= 1'b1;
  end
  mask_read_a: assert property (live_q && i_cmd.valid && i_cmd.op == srss_pkg::SRSS_OP_SRE_QUERY
    |=> o_reply.valid && (o_reply.data & ~srss_pkg::SRSS_MASK_READ) == 8'h00) else $error("mask reply bad");
  stb_bits_a: assert property (live_q && i_cmd.valid && i_cmd.op == srss_pkg::SRSS_OP_STB_QUERY
    |=> o_reply.valid && o_reply.data[5] == $past(esb_w) && o_reply.data[4] == $past(i_queue_has_data)
    && o_reply.data[7] == 1'b0 && o_reply.data[3:0] == 4'h0) else $error("status reply bad");
  trig_block_a: assert property (go_w && i_osc_mode != srss_pkg::SRSS_MODE_TRIGGERED |=> !o_trigger)
    else $error("trigger not ignored");
  trig_fire_a: assert property (go_w && i_osc_mode == srss_pkg::SRSS_MODE_TRIGGERED |=> o_trigger)
    else $error("trigger missing");
  rcl_noarg_a: assert property (live_q && i_cmd.valid && i_cmd.op == srss_pkg::SRSS_OP_RECALL
    && !i_cmd.has_param |=> o_cmd_error ##2 !o_setup_load) else $error("recall without slot");
  rcl_load_a: assert property (slot_w && i_cmd.op == srss_pkg::SRSS_OP_RECALL && rnd_w >= 17'sd1
    && rnd_w <= 17'sd9 |-> ##3 o_setup_load) else $error("recall not loaded");
  slot_err_a: assert property (slot_w && (i_cmd.op == srss_pkg::SRSS_OP_RECALL
    || i_cmd.op == srss_pkg::SRSS_OP_SAVE) && (rnd_w < 17'sd1 || rnd_w > 17'sd9) |=> o_exe_error)
    else $error("slot error missing");
  poll_byte_a: assert property (live_q && i_serial_poll |=> o_poll_valid && o_poll_byte[5] == $past(esb_w)
    && o_poll_byte[7] == 1'b0 && o_poll_byte[3:0] == 4'h0) else $error("poll byte bad");
  srq_mss_a: assert property ($rose(o_srq) |-> o_mss) else $error("request without summary");
  cover property (o_setup_load);
  cover property (o_trigger);
  cover property (o_poll_valid && o_poll_byte[6]);
endmodule // srss_top_properties
bind srss_top srss_top_properties u_props (
  .i_clock(i_clock), .i_rst(i_rst), .i_cmd(i_cmd), .i_group_trigger(i_group_trigger),
  .i_serial_poll(i_serial_poll), .i_event_status(i_event_status), .i_event_enable(i_event_enable),
  .i_queue_has_data(i_queue_has_data), .i_osc_mode(i_osc_mode), .o_reply(o_reply),
  .o_poll_byte(o_poll_byte), .o_poll_valid(o_poll_valid), .o_srq(o_srq), .o_mss(o_mss),
  .o_trigger(o_trigger), .o_setup_load(o_setup_load), .o_cmd_error(o_cmd_error), .o_exe_error(o_exe_error)
);
`default_nettype wire

// ---- verification/srss_top_tb.sv ----
// Purpose: Self-checking bench against an integer model of mask, status and slots
// Assumes: Inputs change at the falling edge
// Notes:   Slot parameters are sent in fixed point with four fraction bits
`timescale 1ns/1ns
`default_nettype none
module srss_top_tb;
  logic clk = 1'b0, rst = 1'b1, psc = 1'b0, gt, sp, qd = 1'b0;
  logic poll_v, srq, mss, trig, load, cerr, xerr;
  logic [7:0] ev_st = 8'h00, ev_en = 8'h00, kept = 8'h00, poll_byte, mask_keep;
  logic [31:0] setup = 32'h00000000, setup_o;
  srss_pkg::srss_cmd_t cmd;
  srss_pkg::srss_mode_t mode = srss_pkg::SRSS_MODE_TRIGGERED;
  srss_pkg::srss_reply_t reply;
  int bad_count = 0, n_tests = 0, mask_m, v, s, m;
  int unsigned seed = 12792;
  int bad_p[3] = '{7, 152, -16};
  logic [31:0] store[1:9];
  srss_host host (.i_clock(clk), .o_cmd(cmd), .o_group_trigger(gt), .o_serial_poll(sp));
  srss_top DUT (
    .i_clock(clk), .i_rst(rst), .i_cmd(cmd), .i_group_trigger(gt), .i_serial_poll(sp),
    .i_event_status(ev_st), .i_event_enable(ev_en), .i_queue_has_data(qd), .i_osc_mode(mode),
    .i_psc_flag(psc), .i_kept_mask(kept), .i_setup(setup), .o_reply(reply), .o_poll_byte(poll_byte),
    .o_poll_valid(poll_v), .o_srq(srq), .o_mss(mss), .o_mask_keep(mask_keep), .o_trigger(trig),
    .o_setup(setup_o), .o_setup_load(load), .o_cmd_error(cerr), .o_exe_error(xerr)
  );
  initial forever #5 clk = ~clk;
  function automatic int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] stb_exp();
    logic e;
    e = |(ev_st & ev_en);
    return {1'b0, (e & mask_m[5]) | (qd & mask_m[4]), e, qd, 4'h0};
  endfunction
  task automatic chk_val(input logic [32:0] got, input logic [32:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    chk_val({32'h0, got}, {32'h0, exp}, what);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic do_reset(input logic p, input logic [7:0] k);
    rst = 1'b1;
    psc = p;
    kept = k;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    mask_m = p ? 0 : k;
    @(negedge clk);
  endtask
  task automatic query(input srss_pkg::srss_op_t op, input logic [7:0] exp);
    host.send(op, 1'b0, 0);
    chk_val({reply.valid, reply.data}, {1'b1, exp}, "query reply");
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    $display("BAD %0t run too long", $time);
    test_done();
  end
  initial begin
    do_reset(1'b0, 8'hf0);
    query(srss_pkg::SRSS_OP_SRE_QUERY, 8'h30);
    chk_val(mask_keep, 8'hf0, "kept mask");
    do_reset(1'b1, 8'hff);
    query(srss_pkg::SRSS_OP_SRE_QUERY, 8'h00);
    for (int i = 0; i < 40; i++) begin
      v = rnd() % 300;
      host.send(srss_pkg::SRSS_OP_SRE_SET, 1'b1, v * 16 + (rnd() % 16) - 8);
      chk_bit(xerr, v > 255, "mask range");
      if (v <= 255) mask_m = v;
      query(srss_pkg::SRSS_OP_SRE_QUERY, 8'(mask_m) & 8'h30);
      chk_val(mask_keep, mask_m[7:0], "mask copy");
      ev_st = 8'(rnd());
      ev_en = 8'(rnd());
      qd = 1'(rnd());
      mode = srss_pkg::srss_mode_t'(rnd() % 4);
      query(srss_pkg::SRSS_OP_STB_QUERY, stb_exp());
      chk_bit(mss, (stb_exp() & 8'h40) != 8'h00, "summary");
      host.send(srss_pkg::SRSS_OP_TRIGGER, 1'b0, 0);
      chk_bit(trig, mode == srss_pkg::SRSS_MODE_TRIGGERED, "trigger cmd");
      host.pulse(1'b0);
      chk_bit(trig, mode == srss_pkg::SRSS_MODE_TRIGGERED, "group trigger");
    end
    host.send(srss_pkg::SRSS_OP_RECALL, 1'b0, 0);
    chk_bit(cerr, 1'b1, "recall no slot");
    for (s = 9; s >= 1; s--) begin
      setup = rnd();
      store[s] = setup;
      host.send(srss_pkg::SRSS_OP_SAVE, 1'b1, s * 16 - 8 + (rnd() % 16));
      chk_bit(xerr, 1'b0, "save ok");
    end
    foreach (bad_p[i]) begin
      setup = ~setup;
      host.send(srss_pkg::SRSS_OP_SAVE, 1'b1, bad_p[i]);
      chk_bit(xerr, 1'b1, "save range");
    end
    for (s = 1; s <= 9; s++) begin
      host.send(srss_pkg::SRSS_OP_RECALL, 1'b1, s * 16);
      repeat (2) @(negedge clk);
      chk_val({load, setup_o}, {1'b1, store[s]}, "recall data");
    end
    foreach (bad_p[i]) begin
      host.send(srss_pkg::SRSS_OP_RECALL, 1'b1, bad_p[i]);
      chk_bit(xerr, 1'b1, "recall range");
      repeat (2) @(negedge clk);
      chk_val({load, setup_o}, {1'b0, store[9]}, "recall skipped");
    end
    for (m = 16; m <= 32; m += 16) begin
      host.send(srss_pkg::SRSS_OP_SRE_SET, 1'b1, m * 16);
      mask_m = m;
      ev_st = 8'h00;
      qd = 1'b0;
      host.pulse(1'b1);
      ev_st = 8'h01;
      ev_en = 8'h01;
      repeat (2) @(negedge clk);
      chk_bit(srq, m == 32, "request set");
    end
    host.pulse(1'b1);
    chk_val({poll_v, poll_byte}, {1'b1, 8'h60}, "poll byte");
    @(negedge clk);
    chk_bit(srq, 1'b0, "request cleared");
    host.pulse(1'b1);
    chk_val({poll_v, poll_byte}, {1'b1, 8'h20}, "poll after clear");
    test_done();
  end
endmodule // srss_top_tb
`default_nettype wire
